// File: src/sfb_dev.sv
// Summary of operation
// (R1) Frame: sixteen bits, address byte, data byte
// (R2) Data bits D0..D7 on frame bits 8..15
// (R3) Mode bit zero reads, no change
// (R4) Mode bit one clears addressed byte
// (R5) Flags latch; only watchdog count moves alone; the code also reads the levels at 48, 72, 73 live
// (R6) One address selects each status register
// (R7) Read-only identification register at 7E
// (R8) Reserved reads zero; read-only survives clear
// (R9) Supply undervoltage latches only regulator enabled
// (R10) Supply overvoltage latches only regulator enabled
// (R11) Regulator overvoltage latches bit one
// (R12) Below prewarning threshold latches bit zero
// (R13) Prewarning threshold fixed, separate from reset
// (R14) Supply fail register resets to zero
// (R15) Restart zeroes 7,4,3,2, keeps others
// (R16) Stop mode suspends undervoltage monitoring
// (R17) Stop mode monitors on peak or prewarning
// (R18) Overvoltage always monitored with charge pump
// (R19) Clear hits only clearable bits; set wins
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "sfb_cfg.svh"
module sfb_dev #(
    parameter logic [7:0] PREWARN_TH = `SFB_PREWARN_TH,
    parameter logic [7:0] FAMILY_ID = `SFB_FAMILY_ID,
    parameter int NAUX = `SFB_NAUX,
    parameter int NLVL = `SFB_NLVL
) (
    input logic clk,
    input logic sys_rst,
    sfb_link_if.dev link,
    input logic soft_reset,
    input logic restart,
    input logic stop_mode,
    input logic main_reg_enabled,
    input logic [7:0] main_reg_level,
    input logic sup_uv_detect,
    input logic sup_ov_detect,
    input logic main_reg_ov_detect,
    input logic load_above_peak,
    input logic charge_pump_enable,
    input logic [1:0] watchdog_failure_count,
    input logic [NAUX*8-1:0] aux_event,
    input logic [NLVL*8-1:0] aux_level,
    output logic [7:0] supply_fail_status
);

////////////////////////////////////////////////////////////////////////////////
// Sticky register table

localparam logic [6:0] AUX_ADDR [NAUX] = '{
    `SFB_ADDR_SUP_B, `SFB_ADDR_THERM, `SFB_ADDR_DEV_INFO, `SFB_ADDR_BUS,
    `SFB_ADDR_WAKE_A, `SFB_ADDR_WAKE_B, `SFB_ADDR_GPIO_OC,
    `SFB_ADDR_GPIO_OL, `SFB_ADDR_SWK, `SFB_ADDR_SWK_ECNT
};
localparam logic [7:0] AUX_MASK [NAUX] = '{
    `SFB_MASK_SUP_B, `SFB_MASK_THERM, `SFB_MASK_DEV_INFO, `SFB_MASK_ALL,
    `SFB_MASK_ALL, `SFB_MASK_ALL, `SFB_MASK_ALL,
    `SFB_MASK_ALL, `SFB_MASK_ALL, `SFB_MASK_ALL
};

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

logic [1:0] csn_sync_reg;
logic [1:0] sclk_sync_reg;
logic [1:0] mosi_sync_reg;
logic csn_q_reg;
logic sclk_q_reg;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        csn_sync_reg <= 2'h3;
        sclk_sync_reg <= 2'h0;
        mosi_sync_reg <= 2'h0;
        csn_q_reg <= 1'h1;
        sclk_q_reg <= 1'h0;
    end else begin
        csn_sync_reg <= {csn_sync_reg[0], link.csn_n};
        sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
        mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
        csn_q_reg <= csn_sync_reg[1];
        sclk_q_reg <= sclk_sync_reg[1];
    end
end

logic csn_fall;
logic csn_rise;
logic sclk_rise;
logic mosi_s;
assign csn_fall = ~csn_sync_reg[1] & csn_q_reg;
assign csn_rise = csn_sync_reg[1] & ~csn_q_reg;
assign sclk_rise = sclk_sync_reg[1] & ~sclk_q_reg & ~csn_sync_reg[1];
assign mosi_s = mosi_sync_reg[1];

////////////////////////////////////////////////////////////////////////////////
// Frame receiver

logic [4:0] bit_cnt_reg;
logic [7:0] hdr_reg;
logic [7:0] tx_reg;
logic [7:0] rd_byte;
logic [6:0] addr;
logic clr_now;

assign addr = hdr_reg[6:0];

always_ff @(posedge clk) begin
    if (sys_rst || csn_fall) begin
        bit_cnt_reg <= 5'h00;
        hdr_reg <= 8'h00;
    end else if (sclk_rise && bit_cnt_reg != `SFB_FRAME_BITS) begin
        if (bit_cnt_reg < `SFB_HDR_BITS) begin
            hdr_reg[bit_cnt_reg[2:0]] <= mosi_s; // [R1]
        end
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
end

// Answer byte goes out on the second half of the frame
always_ff @(posedge clk) begin
    if (sys_rst || csn_fall) begin
        tx_reg <= 8'h00;
    end else if (sclk_rise) begin
        if (bit_cnt_reg == `SFB_HDR_BITS - 5'h01) begin
            tx_reg <= rd_byte; // [R2]
        end else if (bit_cnt_reg >= `SFB_HDR_BITS) begin
            tx_reg <= {1'h0, tx_reg[7:1]}; // [R2]
        end
    end
end

assign link.miso = tx_reg[0];

// Only a complete frame with mode bit set clears
assign clr_now = csn_rise && bit_cnt_reg == `SFB_FRAME_BITS
    && hdr_reg[`SFB_MODE_BIT]; // [R3] [R4]

////////////////////////////////////////////////////////////////////////////////
// Supply fail register

logic [7:0] sup_a_reg;
logic [7:0] sup_set;
logic prewarn_now;
logic monitor_ext;
logic clr_sup;

assign prewarn_now = main_reg_enabled
    && main_reg_level < PREWARN_TH; // [R12] [R13]
assign monitor_ext = ~stop_mode | load_above_peak
    | sup_a_reg[`SFB_BIT_REG_WARN]; // [R16] [R17]
assign clr_sup = clr_now && addr == `SFB_ADDR_SUP_A; // [R6]

always_comb begin
    sup_set = 8'h00;
    sup_set[`SFB_BIT_SUP_UV] = main_reg_enabled & monitor_ext
        & sup_uv_detect; // [R9] [R16] [R17]
    sup_set[`SFB_BIT_SUP_OV] = main_reg_enabled
        & (charge_pump_enable | monitor_ext) & sup_ov_detect; // [R10] [R18]
    sup_set[`SFB_BIT_REG_OV] = main_reg_ov_detect; // [R11]
    sup_set[`SFB_BIT_REG_WARN] = prewarn_now; // [R12]
end

always_ff @(posedge clk) begin
    if (sys_rst || soft_reset) begin
        sup_a_reg <= `SFB_SUP_A_RST; // [R14]
    end else if (restart) begin
        sup_a_reg <= (sup_a_reg | sup_set) & `SFB_SUP_A_KEEP; // [R15]
    end else begin
        sup_a_reg <= ((sup_a_reg & ~(clr_sup ? `SFB_SUP_A_MASK : 8'h00))
            | sup_set) & `SFB_SUP_A_MASK; // [R5] [R19] [R8]
    end
end

assign supply_fail_status = sup_a_reg;

////////////////////////////////////////////////////////////////////////////////
// Other sticky registers

logic [7:0] aux_reg [NAUX];

for (genvar i = 0; i < NAUX; i++) begin : g_aux
    logic hit;
    assign hit = clr_now && addr == AUX_ADDR[i]; // [R6]
    always_ff @(posedge clk) begin
        if (sys_rst || soft_reset) begin
            aux_reg[i] <= 8'h00;
        end else begin
            aux_reg[i] <= ((aux_reg[i] & ~(hit ? AUX_MASK[i] : 8'h00))
                | aux_event[i*8 +: 8]) & AUX_MASK[i]; // [R5] [R19]
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read multiplexer

always_comb begin
    rd_byte = 8'h00; // [R8]
    case (addr)
        `SFB_ADDR_SUP_A: begin
            rd_byte = sup_a_reg; // [R3]
        end
        `SFB_ADDR_WAKE_LVL: begin
            rd_byte = aux_level[7:0]; // [R8]
        end
        `SFB_ADDR_CDR_A: begin
            rd_byte = aux_level[15:8];
        end
        `SFB_ADDR_CDR_B: begin
            rd_byte = aux_level[23:16];
        end
        `SFB_ADDR_FAM_ID: begin
            rd_byte = FAMILY_ID; // [R7]
        end
        default: begin
            rd_byte = 8'h00;
        end
    endcase
    for (int i = 0; i < NAUX; i++) begin
        if (addr == AUX_ADDR[i]) begin
            rd_byte = aux_reg[i]; // [R6]
        end
    end
    if (addr == `SFB_ADDR_DEV_INFO) begin
        rd_byte[`SFB_WD_LSB +: 2] = watchdog_failure_count; // [R5] [R8]
    end
end

endmodule

// File: pkg/sfb_cfg.svh
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH

// Frame layout
`define SFB_FRAME_BITS 5'h10
`define SFB_HDR_BITS 5'h08
`define SFB_MODE_BIT 3'h7
`define SFB_ADDR_W 7

// Register addresses
`define SFB_ADDR_SUP_A 7'h40
`define SFB_ADDR_SUP_B 7'h41
`define SFB_ADDR_THERM 7'h42
`define SFB_ADDR_DEV_INFO 7'h43
`define SFB_ADDR_BUS 7'h44
`define SFB_ADDR_WAKE_A 7'h46
`define SFB_ADDR_WAKE_B 7'h47
`define SFB_ADDR_WAKE_LVL 7'h48
`define SFB_ADDR_GPIO_OC 7'h54
`define SFB_ADDR_GPIO_OL 7'h55
`define SFB_ADDR_SWK 7'h70
`define SFB_ADDR_SWK_ECNT 7'h71
`define SFB_ADDR_CDR_A 7'h72
`define SFB_ADDR_CDR_B 7'h73
`define SFB_ADDR_FAM_ID 7'h7E

// Supply fail register fields
`define SFB_BIT_SUP_UV 6
`define SFB_BIT_SUP_OV 5
`define SFB_BIT_REG_OV 1
`define SFB_BIT_REG_WARN 0
`define SFB_SUP_A_RST 8'h00
`define SFB_SUP_A_KEEP 8'h63
`define SFB_SUP_A_MASK 8'h63

// Clearable masks of the other sticky registers
`define SFB_MASK_SUP_B 8'h9D
`define SFB_MASK_THERM 8'h0F
`define SFB_MASK_DEV_INFO 8'hC3
`define SFB_MASK_ALL 8'hFF
`define SFB_WD_LSB 2
`define SFB_NAUX 10
`define SFB_NLVL 3

// Arbitrary identification value
`define SFB_FAMILY_ID 8'h5A
`define SFB_PREWARN_TH 8'h80

// Host timing and registers
`define SFB_HALF_CYC 4'h8
`define SFB_HREG_CMD 5'h00
`define SFB_HREG_STATUS 5'h04
`define SFB_HREG_RXDATA 5'h08
`define SFB_HREG_IRQ_STAT 5'h0C
`define SFB_HREG_IRQ_MASK 5'h10

`endif

// File: pkg/sfb_pkg.sv
package sfb_pkg;
    typedef logic [7:0] sfb_byte_t;
    typedef enum logic [1:0] {
        SFB_IDLE = 2'h0,
        SFB_LOW = 2'h1,
        SFB_HIGH = 2'h3,
        SFB_TRAIL = 2'h2
    } sfb_state_e;
endpackage

// File: pkg/sfb_link_if.sv
`timescale 1ns/1ns
interface sfb_link_if;
    logic csn_n;
    logic sclk;
    logic mosi;
    logic miso;
    modport dev (
        input csn_n,
        input sclk,
        input mosi,
        output miso
    );
    modport host (
        output csn_n,
        output sclk,
        output mosi,
        input miso
    );
endinterface

// File: src/sfb_host.sv
`timescale 1ns/1ns
`include "sfb_cfg.svh"
module sfb_host #(
    parameter logic [3:0] HALF_CYC = `SFB_HALF_CYC
) (
    input logic clk,
    input logic sys_rst,
    sfb_link_if.host link,
    input logic [4:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// Link engine

sfb_pkg::sfb_state_e state_reg;
logic [1:0] miso_sync_reg;
logic [3:0] div_reg;
logic [3:0] bit_reg;
logic [15:0] cmd_reg;
logic [15:0] rx_reg;
logic csn_n_reg;
logic sclk_reg;
logic mosi_reg;
logic tick;
logic start;
logic done;

assign tick = div_reg == HALF_CYC - 4'h1;
assign start = reg_wr && reg_addr == `SFB_HREG_CMD
    && state_reg == sfb_pkg::SFB_IDLE;
assign done = tick && state_reg == sfb_pkg::SFB_TRAIL;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        miso_sync_reg <= 2'h0;
    end else begin
        miso_sync_reg <= {miso_sync_reg[0], link.miso};
    end
end

always_ff @(posedge clk) begin
    if (sys_rst || state_reg == sfb_pkg::SFB_IDLE || tick) begin
        div_reg <= 4'h0;
    end else begin
        div_reg <= div_reg + 4'h1;
    end
end

always_ff @(posedge clk) begin
    if (sys_rst) begin
        state_reg <= sfb_pkg::SFB_IDLE;
        bit_reg <= 4'h0;
        cmd_reg <= 16'h0000;
        rx_reg <= 16'h0000;
        csn_n_reg <= 1'h1;
        sclk_reg <= 1'h0;
        mosi_reg <= 1'h0;
    end else begin
        case (state_reg)
            sfb_pkg::SFB_IDLE: begin
                if (start) begin
                    cmd_reg <= reg_wdata;
                    bit_reg <= 4'h0;
                    mosi_reg <= reg_wdata[0];
                    csn_n_reg <= 1'h0;
                    state_reg <= sfb_pkg::SFB_LOW;
                end
            end
            sfb_pkg::SFB_LOW: begin
                if (tick) begin
                    sclk_reg <= 1'h1;
                    rx_reg[bit_reg] <= miso_sync_reg[1];
                    state_reg <= sfb_pkg::SFB_HIGH;
                end
            end
            sfb_pkg::SFB_HIGH: begin
                if (tick) begin
                    sclk_reg <= 1'h0;
                    if (bit_reg == 4'hF) begin
                        state_reg <= sfb_pkg::SFB_TRAIL;
                    end else begin
                        bit_reg <= bit_reg + 4'h1;
                        mosi_reg <= cmd_reg[bit_reg + 4'h1];
                        state_reg <= sfb_pkg::SFB_LOW;
                    end
                end
            end
            sfb_pkg::SFB_TRAIL: begin
                if (tick) begin
                    csn_n_reg <= 1'h1;
                    state_reg <= sfb_pkg::SFB_IDLE;
                end
            end
            default: begin
                state_reg <= sfb_pkg::SFB_IDLE;
            end
        endcase
    end
end

assign link.csn_n = csn_n_reg;
assign link.sclk = sclk_reg;
assign link.mosi = mosi_reg;

////////////////////////////////////////////////////////////////////////////////
// Software registers and interrupt

logic irq_stat_reg;
logic irq_mask_reg;
logic stat_clr;

assign stat_clr = reg_wr && reg_addr == `SFB_HREG_IRQ_STAT && reg_wdata[0];

always_ff @(posedge clk) begin
    if (sys_rst) begin
        irq_stat_reg <= 1'h0;
        irq_mask_reg <= 1'h0;
    end else begin
        irq_stat_reg <= (irq_stat_reg & ~stat_clr) | done;
        if (reg_wr && reg_addr == `SFB_HREG_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[0];
        end
    end
end

assign irq = irq_stat_reg & irq_mask_reg;

always_ff @(posedge clk) begin
    if (sys_rst) begin
        reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
        case (reg_addr)
            `SFB_HREG_CMD: reg_rdata <= cmd_reg;
            `SFB_HREG_STATUS: begin
                reg_rdata <= {15'h0000, state_reg != sfb_pkg::SFB_IDLE};
            end
            `SFB_HREG_RXDATA: reg_rdata <= {8'h00, rx_reg[15:8]};
            `SFB_HREG_IRQ_STAT: reg_rdata <= {15'h0000, irq_stat_reg};
            `SFB_HREG_IRQ_MASK: reg_rdata <= {15'h0000, irq_mask_reg};
            default: reg_rdata <= 16'h0000;
        endcase
    end else begin
        reg_rdata <= 16'h0000;
    end
end

endmodule

// File: verif/sfb_link_asserts.sv
`timescale 1ns/1ns
module sfb_link_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic csn_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    logic sclk_q;
    logic [4:0] rise_cnt;
    always_ff @(posedge clk) begin
        sclk_q <= sys_rst ? 1'b0 : sclk;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || csn_n) begin
            rise_cnt <= 5'h00;
        end else if (sclk && !sclk_q) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sclk_idle_a: assert property (csn_n |-> !sclk)
        else $error("sclk active outside frame");
    lead_in_a: assert property ($fell(csn_n) |-> !sclk [*8] ##1 sclk)
        else $error("lead in not eight cycles");
    high_half_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("sclk high phase wrong");
    low_half_a: assert property ($fell(sclk) && rise_cnt < 5'h10
        |-> !sclk [*8] ##1 sclk) else $error("sclk low phase wrong");
    trail_a: assert property ($fell(sclk) && rise_cnt == 5'h10
        |-> !csn_n [*8] ##1 csn_n) else $error("frame trail wrong");
    frame_bits_a: assert property ($rose(csn_n) |-> rise_cnt == 5'h10)
        else $error("frame not sixteen bits");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    header_miso_a: assert property (!csn_n && rise_cnt < 5'h08
        |-> !miso) else $error("miso not zero in header");
    cover property ($rose(csn_n));
    cover property (!csn_n && miso);
    cover property ($rose(csn_n) ##[1:40] $fell(csn_n));
endmodule

// File: verif/tb_spi_status_register_bank.sv
`timescale 1ns/1ns
`include "sfb_cfg.svh"
module tb_spi_status_register_bank;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_reset = 1'b0, restart = 1'b0, stop_mode = 1'b0;
    logic reg_en = 1'b1, sup_uv = 1'b0, sup_ov = 1'b0, reg_ov = 1'b0;
    logic peak = 1'b0, cp = 1'b0;
    logic [7:0] level = 8'hFF;
    logic [1:0] wd = 2'h0;
    logic [79:0] aux_ev = 80'h0;
    logic [23:0] aux_lv = 24'h0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] reg_rdata, d;
    logic irq;
    logic [7:0] sup, got;
    int mismatches = 0, total_checks = 0;
    // Condition {stop,en,uv,ov,reg_ov,peak,cp}, level, expected flags
    logic [6:0] rc [13] = '{7'h30, 7'h10, 7'h28, 7'h08, 7'h24, 7'h20,
        7'h20, 7'h70, 7'h72, 7'h70, 7'h68, 7'h69, 7'h6A};
    logic [7:0] rl [13] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F,
        8'h80, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] re [13] = '{8'h40, 8'h00, 8'h20, 8'h00, 8'h02, 8'h01,
        8'h00, 8'h00, 8'h40, 8'h41, 8'h00, 8'h20, 8'h20};
    // Address, mode, expected byte
    logic [6:0] ha [8] = '{7'h42, 7'h42, 7'h43, 7'h43, 7'h48, 7'h48,
        7'h7E, 7'h45};
    logic hm [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] he [8] = '{8'h0F, 8'h00, 8'hCB, 8'h08, 8'hA5, 8'hA5,
        `SFB_FAMILY_ID, 8'h00};
    sfb_link_if link_inst ();
    sfb_dev sfb_dev_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link_inst.dev), .soft_reset(soft_reset), .restart(restart),
        .stop_mode(stop_mode), .main_reg_enabled(reg_en),
        .main_reg_level(level), .sup_uv_detect(sup_uv),
        .sup_ov_detect(sup_ov), .main_reg_ov_detect(reg_ov),
        .load_above_peak(peak), .charge_pump_enable(cp),
        .watchdog_failure_count(wd), .aux_event(aux_ev),
        .aux_level(aux_lv), .supply_fail_status(sup));
    sfb_host sfb_host_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link_inst.host), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    sfb_link_asserts sfb_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
        .csn_n(link_inst.csn_n), .sclk(link_inst.sclk),
        .mosi(link_inst.mosi), .miso(link_inst.miso));
    ////////////////////////////////////////
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: byte %h not %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: flag %b not %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic frame(input logic [6:0] a, input logic m,
        output logic [7:0] b);
        logic [15:0] v;
        int n;
        wr(`SFB_HREG_CMD, {8'h00, m, a});
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            mismatches++;
            $display("wrong value at %0t: frame never ended", $time);
            complete_run();
        end
        rd(`SFB_HREG_RXDATA, v);
        b = v[7:0];
        wr(`SFB_HREG_IRQ_STAT, 16'h0001);
        repeat (6) @(posedge clk);
    endtask
    task automatic cond(input logic [6:0] c, input logic [7:0] l);
        @(posedge clk);
        {stop_mode, reg_en, sup_uv, sup_ov, reg_ov, peak, cp} <= c;
        level <= l;
        repeat (3) @(posedge clk);
        {stop_mode, reg_en, sup_uv, sup_ov, reg_ov, peak, cp} <= 7'h20;
        level <= 8'hFF;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk8(sup, 8'h00);
        chk1(link_inst.csn_n, 1'b1);
        chk1(irq, 1'b0);
        repeat (4) @(posedge clk);
        wr(`SFB_HREG_IRQ_MASK, 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            cond(rc[i], rl[i]);
            chk8(sup, re[i]);
            frame(7'h40, 1'b1, got);
            chk8(got, re[i]);
            chk8(sup, 8'h00);
        end
        $display("test supply rows done");
        cond(7'h30, 8'hFF);
        frame(7'h40, 1'b0, got);
        chk8(got, 8'h40);
        repeat (20) @(posedge clk);
        chk8(sup, 8'h40);
        sup_uv <= 1'b1;
        frame(7'h40, 1'b1, got);
        chk8(sup, 8'h40);
        sup_uv <= 1'b0;
        frame(7'h40, 1'b1, got);
        chk8(sup, 8'h00);
        $display("test read and set wins done");
        cond(7'h34, 8'hFF);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (2) @(posedge clk);
        chk8(sup, 8'h42);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk8(sup, 8'h00);
        $display("test restart done");
        aux_ev <= 80'hFFFF00;
        wd <= 2'h2;
        aux_lv <= 24'h0000A5;
        repeat (2) @(posedge clk);
        aux_ev <= 80'h0;
        for (int i = 0; i < 8; i++) begin
            frame(ha[i], hm[i], got);
            chk8(got, he[i]);
        end
        $display("test other registers done");
        wr(`SFB_HREG_IRQ_MASK, 16'h0000);
        wr(`SFB_HREG_CMD, {8'h00, 1'b0, 7'h7E});
        rd(`SFB_HREG_STATUS, d);
        chk1(d[0], 1'b1);
        rd(`SFB_HREG_CMD, d);
        chk8(d[7:0], 8'h7E);
        chk8(d[15:8], 8'h00);
        @(posedge clk);
        #1 chk8(reg_rdata[7:0], 8'h00);
        repeat (300) @(posedge clk);
        chk1(irq, 1'b0);
        rd(`SFB_HREG_STATUS, d);
        chk1(d[0], 1'b0);
        rd(`SFB_HREG_IRQ_STAT, d);
        chk1(d[0], 1'b1);
        wr(`SFB_HREG_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge clk);
        chk1(irq, 1'b1);
        wr(`SFB_HREG_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge clk);
        chk1(irq, 1'b0);
        $display("test interrupt done");
        complete_run();
    end
endmodule
